// [cms_params.svh]
/*
 * constants for the configuration mode sequencer: timing, id code layout.
 * assumes a 100 MHz system clock; included by its bare name.
 */
`ifndef CMS_PARAMS_SVH
`define CMS_PARAMS_SVH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CMS_CLK_MHZ 100
`define CMS_POR_LONG_MS 100
`define CMS_POR_SHORT_MS 12
// milliseconds times 1000 gives microseconds, times the clock in MHz gives cycles
`define CMS_POR_LONG_CYC (`CMS_POR_LONG_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_POR_SHORT_CYC (`CMS_POR_SHORT_MS * 1000 * `CMS_CLK_MHZ)
`define CMS_INIT_CYC 16

// ------------------------------------------------------------
// identification code
// ------------------------------------------------------------
`define CMS_IDCODE_LSB_POS 0
`define CMS_IDCODE_LSB_VAL 1'h1

`endif

// [cms_pkg.sv]
/*
 * types for the configuration mode sequencer.
 * assumes cms_params.svh holds the numeric constants.
 */
package cms_pkg;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_POR = 3'b000,
        ST_WAIT_CFG = 3'b001,
        ST_CONFIG = 3'b010,
        ST_INIT = 3'b011,
        ST_USER = 3'b100
    } seq_state_t;

    // ------------------------------------------------------------
    // external pin group, as held in the two synchroniser stages
    // ------------------------------------------------------------
    typedef struct packed {
        logic por_delay_select;
        logic preconfig_pullup_disable;
        logic reconfig_request_n;
    } pins_t;

endpackage

// [config_mode_sequencer.sv]
/*
 * power-up and command/user mode sequencer of a volatile programmable device.
 * assumes config_done_in comes from the config loader on sys_clk_in; pins are
 * asynchronous and synchronised here; reconfig_pulse_in is a one-cycle
 * pulse from the test-port logic on sys_clk_in.
 */
// Operation
// (R1) user I/O stays high impedance during power-up, waiting and configuration.
// (R2) after every power-up a complete configuration load is needed to leave command mode.
// (R3) after configuration an initialization phase resets registers then enables the I/O; the code enables it from the second init cycle.
// (R4) command mode (configuration plus initialization) and user mode are tracked and shown apart.
// (R5) a low reconfiguration request in user mode returns to command mode and reloads.
// (R6) delay select low gives a 100 ms power-on delay, high gives 12 ms.
// (R7) pull-up select high disables weak pull-ups before and during configuration, low enables.
// (R8) the 32-bit id code always has its least significant bit at 1, msb listed first; idcode_out resets to zero and reads 0 until the first edge after reset.
// (R9) the system places the device within the first 17 positions of the scan chain.
// (R10) the reconfiguration test instruction acts like a low pulse on the request pin.
// (R11) internal reset is held until a counter has measured the selected delay.
`timescale 1ns/1ps
`include "cms_params.svh"

module config_mode_sequencer
    import cms_pkg::*;
#(
    parameter int unsigned POR_LONG_CYC = `CMS_POR_LONG_CYC,
    parameter int unsigned POR_SHORT_CYC = `CMS_POR_SHORT_CYC,
    parameter int unsigned INIT_CYC = `CMS_INIT_CYC,
    parameter logic [30:0] ID_UPPER = 31'h0123_4567 // arbitrary value
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic por_delay_select_in,
    input wire logic preconfig_pullup_disable_in,
    input wire logic reconfig_request_n_in,
    input wire logic reconfig_pulse_in,
    input wire logic config_done_in,
    output logic internal_resetn_out,
    output logic config_enable_out,
    output logic io_oe_n_out,
    output logic io_pullup_en_out,
    output logic register_reset_out,
    output logic command_mode_out,
    output logic user_mode_out,
    output logic [31:0] idcode_out
);

    localparam int CW = 32;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pins_t sync1;
        pins_t sync2;
        seq_state_t st;
        logic [CW-1:0] cnt;
        logic [CW-1:0] por_target;
        logic cfg_loaded;
        logic internal_resetn;
        logic config_enable;
        logic io_oe_n;
        logic io_pullup_en;
        logic register_reset;
        logic command_mode;
        logic user_mode;
        logic [31:0] idcode;
    } state_t;

    state_t q, d;

    // delay selected by the strap level
    function automatic logic [CW-1:0] por_cycles(input logic sel);
        por_cycles = sel ? CW'(POR_SHORT_CYC) : CW'(POR_LONG_CYC);
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync1 = {por_delay_select_in, preconfig_pullup_disable_in, reconfig_request_n_in};
        d.sync2 = q.sync1;
        d.idcode = {ID_UPPER, `CMS_IDCODE_LSB_VAL}; // R8
        case (q.st)
            ST_POR: begin
                d.por_target = por_cycles(q.sync2.por_delay_select); // R6
                if (q.cnt >= q.por_target && q.cnt != '0) begin // R11
                    d.st = ST_WAIT_CFG;
                    d.cnt = '0;
                end else begin
                    d.cnt = q.cnt + CW'(1);
                end
            end
            ST_WAIT_CFG: begin
                if (q.sync2.reconfig_request_n) begin
                    d.st = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (!q.sync2.reconfig_request_n || reconfig_pulse_in) begin
                    d.st = ST_WAIT_CFG; // restart the load
                end else if (config_done_in) begin // R2
                    d.cfg_loaded = 1'b1;
                    d.st = ST_INIT;
                    d.cnt = '0;
                end
            end
            ST_INIT: begin
                if (q.cnt >= CW'(INIT_CYC - 1)) begin // R3
                    d.st = ST_USER;
                end else begin
                    d.cnt = q.cnt + CW'(1);
                end
            end
            ST_USER: begin
                if (!q.sync2.reconfig_request_n || reconfig_pulse_in) begin // R5 R10
                    d.st = ST_WAIT_CFG;
                    d.cfg_loaded = 1'b0;
                end
            end
            default: begin
                d.st = ST_POR;
                d.cnt = '0;
            end
        endcase
        // outputs registered from the next state
        d.internal_resetn = (d.st != ST_POR); // R11
        d.config_enable = (d.st == ST_CONFIG);
        d.io_oe_n = (d.st != ST_USER) && !(d.st == ST_INIT && d.cnt > CW'(0)); // R1 R3
        d.io_pullup_en = (d.st != ST_USER) && !q.sync2.preconfig_pullup_disable; // R7
        d.register_reset = (d.st == ST_INIT); // R3
        d.command_mode = (d.st == ST_CONFIG) || (d.st == ST_INIT) || (d.st == ST_WAIT_CFG); // R4
        d.user_mode = (d.st == ST_USER); // R4
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            q <= '0;
            q.st <= ST_POR;
            q.sync1 <= 3'h7;
            q.sync2 <= 3'h7;
            q.io_oe_n <= 1'b1;
            q.command_mode <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign internal_resetn_out = q.internal_resetn;
    assign config_enable_out = q.config_enable;
    assign io_oe_n_out = q.io_oe_n;
    assign io_pullup_en_out = q.io_pullup_en;
    assign register_reset_out = q.register_reset;
    assign command_mode_out = q.command_mode;
    assign user_mode_out = q.user_mode;
    assign idcode_out = q.idcode;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_done_in_config;
        q.st == ST_CONFIG && q.sync2.reconfig_request_n && !reconfig_pulse_in && config_done_in;
    endsequence

    sequence s_init_then_user;
        q.register_reset [*2] ##[1:40] q.user_mode;
    endsequence

    AST_IO_HIZ: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R1
        (q.st == ST_POR || q.st == ST_WAIT_CFG || q.st == ST_CONFIG) |-> q.io_oe_n)
        else $error("io driven outside user mode");
    AST_NEED_LOAD: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R2
        $rose(q.user_mode) |-> q.cfg_loaded)
        else $error("user mode without load");
    AST_INIT_SEQ: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R3
        s_done_in_config |=> s_init_then_user)
        else $error("init did not lead to user mode");
    AST_MODES_APART: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R4
        !(q.command_mode && q.user_mode))
        else $error("both modes shown");
    AST_RECONFIG: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R5
        (q.st == ST_USER && !q.sync2.reconfig_request_n) |=> (q.command_mode && !q.user_mode))
        else $error("request ignored in user mode");
    AST_POR_SEL: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R6
        (q.st == ST_POR && q.cnt > 1)
        |-> q.por_target == por_cycles($past(q.sync2.por_delay_select)))
        else $error("wrong power-on delay chosen");
    AST_PULLUP: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R7
        (q.st == ST_CONFIG && $past(q.st) == ST_CONFIG)
        |-> q.io_pullup_en == !$past(q.sync2.preconfig_pullup_disable))
        else $error("pull-up select not followed");
    AST_ID_LSB: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R8
        $past(resetn_in) |-> q.idcode[`CMS_IDCODE_LSB_POS] == 1'b1)
        else $error("id code lsb not one");
    AST_PULSE: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R10
        (q.st == ST_USER && reconfig_pulse_in) |=> q.st == ST_WAIT_CFG)
        else $error("test pulse ignored");
    AST_POR_HOLD: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R11
        (q.st == ST_POR && q.cnt < q.por_target) |=> !q.internal_resetn)
        else $error("reset released early");
    // loader enable and done handling, init ordering, mode flags, user-mode pull-ups
    AST_CFG_EN_ONLY: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R2
        q.config_enable |-> q.st == ST_CONFIG)
        else $error("loader enabled outside configuration");
    AST_DONE_IGNORED: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R2
        (q.st == ST_WAIT_CFG && config_done_in) |=> q.st != ST_INIT)
        else $error("done taken while waiting");
    AST_IO_FIRST_INIT: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R3
        $rose(q.register_reset) |-> q.io_oe_n)
        else $error("io driven in first init cycle");
    AST_IO_RELEASE: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R3
        (q.register_reset && $past(q.register_reset)) |-> !q.io_oe_n)
        else $error("io not released during init");
    AST_USER_AFTER_INIT: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R3
        $rose(q.user_mode) |-> $past(q.register_reset))
        else $error("user mode without init");
    AST_CMD_IN_INIT: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R4
        q.register_reset |-> (q.command_mode && !q.user_mode))
        else $error("init not shown as command mode");
    AST_PULLUP_USER: assert property (@(posedge sys_clk_in) disable iff (!resetn_in) // R7
        q.user_mode |-> !q.io_pullup_en)
        else $error("pull-ups left on in user mode");

endmodule

// [cfg_host_model.sv]
/*
 * partner model: external configuration loader, one full load per enable.
 * assumes it shares the sequencer clock; slow_in picks a long load.
 */
`timescale 1ns/1ps

module cfg_host_model #(
    parameter int CHAIN_POS = 1
) (
    input wire logic clk_in,
    input wire logic slow_in,
    input wire logic config_enable_in,
    output logic config_done_out
);
    // ------------------------------------------------------------
    // load answer
    // ------------------------------------------------------------
    // answer each enable with one done pulse after a prompt or slow load
    initial begin
        config_done_out = 1'h0;
        forever begin
            @(posedge clk_in);
            if (config_enable_in === 1'h1) begin
                repeat (slow_in ? 40 : 1) @(posedge clk_in);
                config_done_out <= 1'h1;
                @(posedge clk_in);
                config_done_out <= 1'h0;
            end
        end
    end
endmodule

// [config_mode_sequencer_tb_top.sv]
/*
 * testbench for the configuration mode sequencer, mode changes scoreboarded.
 * assumes cfg_host_model stands in for the external configuration loader.
 */
`timescale 1ns/1ps

module config_mode_sequencer_tb_top;
    import cms_pkg::*;
    localparam logic [30:0] ID_UP = 31'h2a5a_1c3b; // arbitrary value
    logic sys_clk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic sel;
    logic pud;
    logic req_n;
    logic rp;
    logic slow;
    logic done, irn, cfg_en, oe_n, pu_en, rr, cm, um;
    logic [31:0] idc;
    logic [2:0] q_exp[$];
    logic [2:0] prev = 3'h0;
    int err_total = 0;
    int check_count = 0;

    // ------------------------------------------------------------
    // clock, design and partner
    // ------------------------------------------------------------
    always #5 sys_clk_in = ~sys_clk_in;
    config_mode_sequencer #(.POR_LONG_CYC(100), .POR_SHORT_CYC(12), .INIT_CYC(16),
        .ID_UPPER(ID_UP)) dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .por_delay_select_in(sel), .preconfig_pullup_disable_in(pud),
        .reconfig_request_n_in(req_n), .reconfig_pulse_in(rp), .config_done_in(done),
        .internal_resetn_out(irn), .config_enable_out(cfg_en), .io_oe_n_out(oe_n),
        .io_pullup_en_out(pu_en), .register_reset_out(rr), .command_mode_out(cm),
        .user_mode_out(um), .idcode_out(idc));
    cfg_host_model partner (.clk_in(sys_clk_in), .slow_in(slow),
        .config_enable_in(cfg_en), .config_done_out(done));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge sys_clk_in);
    endtask
    task automatic bound(int k, int lim);
        if (k >= lim) begin
            chk("wait bound", 32'h0, 32'h1);
            stop_test();
        end
    endtask
    // every change of {internal reset, command, user} while resetn_in is high takes the oldest note
    always @(posedge sys_clk_in) begin
        if (resetn_in === 1'h1 && {irn, cm, um} !== prev) begin
            if (q_exp.size() == 0) begin
                chk("unnoted mode", 32'(prev), 32'({irn, cm, um}));
            end else begin
                chk("mode", 32'(q_exp.pop_front()), 32'({irn, cm, um}));
            end
        end
        prev <= {irn, cm, um};
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset with a strap value, then time the power-on delay
    task automatic por(logic s, int tgt);
        int n = 0;
        resetn_in <= 1'h0;
        sel <= s;
        pud <= 1'($urandom % 2);
        slow <= 1'($urandom % 2);
        tick(6);
        q_exp.push_back(3'h6);
        resetn_in <= 1'h1;
        while (irn !== 1'h1 && n < 400) begin
            tick(1);
            n++;
            if (irn !== 1'h1) chk("por oe_n", 32'h1, 32'(oe_n));
        end
        bound(n, 400);
        chk("por delay", 32'h1, 32'(n >= tgt && n <= tgt + 6));
    endtask
    // run through config and init into user mode
    task automatic to_user();
        int r = 0;
        int k = 0;
        q_exp.push_back(3'h5);
        while (um !== 1'h1 && k < 600) begin
            tick(1);
            k++;
            if (cfg_en === 1'h1) chk("cfg oe_n", 32'h1, 32'(oe_n));
            if (cfg_en === 1'h1) chk("cfg pullup", 32'(!pud), 32'(pu_en));
            if (rr === 1'h1) r++;
        end
        bound(k, 600);
        chk("init cycles", 32'd16, 32'(r));
        chk("user oe_n", 32'h0, 32'(oe_n));
    endtask
    initial begin
        void'($urandom(99508));
        req_n <= 1'h1;
        rp <= 1'h0;
        por(1'h1, 12);
        chk("id lsb", 32'h1, 32'(idc[0]));
        chk("id upper", 32'(ID_UP), 32'(idc[31:1]));
        to_user();
        q_exp.push_back(3'h6);
        rp <= 1'h1;
        tick(1);
        rp <= 1'h0;
        tick(2);
        chk("pulse oe_n", 32'h1, 32'(oe_n));
        to_user();
        q_exp.push_back(3'h6);
        req_n <= 1'h0;
        slow <= 1'h1;
        tick(30);
        chk("held cfg_en", 32'h0, 32'(cfg_en));
        req_n <= 1'h1;
        to_user();
        por(1'h0, 100);
        to_user();
        tick(1);
        chk("notes left", 32'h0, 32'(q_exp.size()));
        stop_test();
    end
endmodule
